//--- sim/fspu_core_model.sv
// fspu_core_model: core that issues store and load program instructions
// assumes it shares aclk with the sequencer; the bench calls its tasks
`timescale 1ns/1ps
`default_nettype none
module fspu_core_model (
  input  wire logic        aclk,
  output logic             store_strobe,
  output logic             load_strobe,
  output logic [15:0]      ptr_addr,
  output logic [15:0]      data_pair,
  output logic             eeprom_write_busy,
  output logic [7:0]       fuse_low_byte,
  output logic [7:0]       fuse_high_byte,
  output logic [7:0]       extended_fuse_byte,
  output logic [4:0]       flash_buf_word,
  input  wire logic [15:0] flash_buf_data
);
  // fixed fuse image, zero bits are programmed
  initial begin
    fuse_low_byte      = 8'h62;
    fuse_high_byte     = 8'hd9;
    extended_fuse_byte = 8'hfd;
    store_strobe       = 1'b0;
    load_strobe        = 1'b0;
    eeprom_write_busy  = 1'b0;
    ptr_addr           = 16'h0000;
    data_pair          = 16'h0000;
    flash_buf_word     = 5'h00;
  end
  // store one cycle after the control write lands, inside the window
  task automatic spm(input logic [15:0] a, input logic [15:0] d);
    @(posedge aclk);
    ptr_addr     <= a;
    data_pair    <= d;
    store_strobe <= 1'b1;
    @(posedge aclk);
    store_strobe <= 1'b0;
    ptr_addr     <= ~a; // pointer reused at once, the latch must not lean on it
    data_pair    <= ~d;
  endtask
  // load instruction for the timed fuse and lock reads
  task automatic lpm(input logic [15:0] a);
    @(posedge aclk);
    ptr_addr    <= a;
    load_strobe <= 1'b1;
    @(posedge aclk);
    load_strobe <= 1'b0;
    ptr_addr    <= ~a;
  endtask
  // eeprom write activity level
  task automatic ee(input logic v);
    @(posedge aclk);
    eeprom_write_busy <= v;
  endtask
  // flash-side buffer look-up, one cycle of latency
  task automatic peek(input logic [4:0] w, output logic [15:0] d);
    @(posedge aclk);
    flash_buf_word <= w;
    @(posedge aclk);
    @(posedge aclk);
    d = flash_buf_data;
  endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
// tb: self-checking bench for the flash self-programming sequencer
// assumes fspu_core with a short program time and the core model beside it
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fspu_pkg::*;
  localparam int         PROG          = 20;
  localparam logic [7:0] FUSE_EXP [4] = '{8'h62, 8'hfa, 8'hfd, 8'hd9};
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        store_strobe, load_strobe, eeprom_write_busy, flash_erase_start, flash_write_start;
  logic        region_read_block, cpu_halt, load_override, prog_irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [4:0]  flash_buf_word;
  logic [6:0]  flash_page;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, fuse_low_byte, fuse_high_byte, extended_fuse_byte, load_data;
  logic [15:0] ptr_addr, data_pair, flash_buf_data, bd;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  int          num_errors, checks_done;

  fspu_core #(.PROG_CYCLES(PROG)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .store_strobe, .load_strobe,
    .ptr_addr, .data_pair, .eeprom_write_busy, .fuse_low_byte, .fuse_high_byte,
    .extended_fuse_byte, .flash_buf_word, .flash_buf_data, .flash_erase_start,
    .flash_write_start, .flash_page, .region_read_block, .cpu_halt, .load_override,
    .load_data, .prog_irq);
  fspu_core_model core_mdl (
    .aclk, .store_strobe, .load_strobe, .ptr_addr, .data_pair, .eeprom_write_busy,
    .fuse_low_byte, .fuse_high_byte, .extended_fuse_byte, .flash_buf_word, .flash_buf_data);

  // 250 MHz core clock
  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk(s_axi_bvalid, 1'b1); // a write that never answers counts as a mismatch
    chk(s_axi_bresp, er);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rvalid, 1'b1); // a read that never answers counts as a mismatch
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask

  // watchdog, the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata  = 32'h0;
    s_axi_wstrb  = 4'hf;
    num_errors   = 0;
    checks_done  = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // reset state, read-only lock byte and an unmapped place
    axr(FSPU_CTRL_OFFS, 32'h00, 2'h0);
    axr(FSPU_LOCK_OFFS, 32'hff, 2'h0);
    axw(FSPU_LOCK_OFFS, 32'h00, 2'h0);
    axr(FSPU_LOCK_OFFS, 32'hff, 2'h0);
    axw(8'h08, 32'h01, 2'h3);
    axr(8'h08, 32'h00, 2'h3);
    core_mdl.peek(5'h00, bd);
    chk(bd, 16'hffff);
    // eeprom activity locks out control writes
    core_mdl.ee(1'b1);
    axw(FSPU_CTRL_OFFS, 32'h83, 2'h0);
    axr(FSPU_CTRL_OFFS, 32'h00, 2'h0);
    core_mdl.ee(1'b0);
    // loads out of order, then an eeprom write throws them away
    axw(FSPU_CTRL_OFFS, 32'h01, 2'h0);
    core_mdl.spm(16'h000a, 16'h1234);
    axw(FSPU_CTRL_OFFS, 32'h01, 2'h0);
    core_mdl.spm(16'h0004, 16'habcd);
    core_mdl.peek(5'h05, bd);
    chk(bd, 16'h1234);
    core_mdl.peek(5'h02, bd);
    chk(bd, 16'habcd);
    core_mdl.ee(1'b1);
    core_mdl.ee(1'b0);
    core_mdl.peek(5'h05, bd);
    chk(bd, 16'hffff);
    axw(FSPU_CTRL_OFFS, 32'h01, 2'h0);
    core_mdl.spm(16'h000a, 16'h1234);
    // erase of a halting page with stray pointer bits set
    axw(FSPU_CTRL_OFFS, 32'h83, 2'h0);
    core_mdl.spm(16'h1c7f, 16'h5a5a);
    #1;
    chk({flash_erase_start, flash_page}, {1'b1, 7'h71});
    chk({cpu_halt, region_read_block, prog_irq}, 3'b110);
    axr(FSPU_CTRL_OFFS, 32'hc3, 2'h0);
    repeat (PROG + 5) @(posedge aclk);
    axr(FSPU_CTRL_OFFS, 32'hc0, 2'h0);
    chk({cpu_halt, prog_irq}, 2'b01);
    // page write to the same page, buffer empties afterwards
    axw(FSPU_CTRL_OFFS, 32'h85, 2'h0);
    core_mdl.spm(16'h1c40, 16'h5a5a);
    #1;
    chk({flash_write_start, flash_page}, {1'b1, 7'h71});
    repeat (PROG + 5) @(posedge aclk);
    core_mdl.peek(5'h05, bd);
    chk(bd, 16'hffff);
    // re-enable clears the busy bit and the buffer
    axw(FSPU_CTRL_OFFS, 32'h81, 2'h0);
    core_mdl.spm(16'h0006, 16'h0f0f);
    axw(FSPU_CTRL_OFFS, 32'h91, 2'h0);
    core_mdl.spm(16'h0000, 16'h0000);
    axr(FSPU_CTRL_OFFS, 32'h80, 2'h0);
    core_mdl.peek(5'h03, bd);
    chk(bd, 16'hffff);
    // lock programming leaves the array readable
    axw(FSPU_CTRL_OFFS, 32'h89, 2'h0);
    core_mdl.spm(16'h0001, 16'h00fa);
    #1;
    chk({cpu_halt, region_read_block}, 2'b00);
    repeat (PROG + 5) @(posedge aclk);
    axr(FSPU_LOCK_OFFS, 32'hfa, 2'h0);
    // timed reads of every fuse and lock address
    for (int i = 0; i < 4; i++) begin
      axw(FSPU_CTRL_OFFS, 32'h89, 2'h0);
      core_mdl.lpm(16'(i));
      #1;
      chk({load_override, load_data}, {1'b1, FUSE_EXP[i]});
      axr(FSPU_CTRL_OFFS, 32'h80, 2'h0);
    end
    // store during eeprom activity is ignored
    axw(FSPU_CTRL_OFFS, 32'h83, 2'h0);
    core_mdl.ee(1'b1);
    core_mdl.spm(16'h0040, 16'h0000);
    #1;
    chk(flash_erase_start, 1'b0);
    core_mdl.ee(1'b0);
    // byte lane 0 masked: the control write is answered but changes nothing
    s_axi_wstrb <= 4'h0;
    axw(FSPU_CTRL_OFFS, 32'h03, 2'h0);
    s_axi_wstrb <= 4'hf;
    axr(FSPU_CTRL_OFFS, 32'h80, 2'h0);
    // no store in the window: command lapses, a late store does nothing
    axw(FSPU_CTRL_OFFS, 32'h83, 2'h0);
    repeat (6) @(posedge aclk);
    axr(FSPU_CTRL_OFFS, 32'h80, 2'h0);
    core_mdl.spm(16'h0040, 16'h0000);
    #1;
    chk({flash_erase_start, region_read_block}, 2'b00);
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- verilog/fspu_core.sv
// fspu_core: flash self-programming sequencer with AXI4-Lite control
// assumes core strobes, pointer, fuse and eeprom signals on aclk
// Summary of operation
// - Erase pattern then store strobe within four cycles erases selected page.
// - Erase ignores data pair and pointer bits outside page index.
// - Work on halting region stalls the core; other region keeps it readable.
// - Load pattern then store strobe writes data word at word index.
// - Buffer words may be loaded in any order.
// - Buffer clears after page write, on re-enable, and on reset.
// - Eeprom write starting during loading discards loaded buffer words.
// - Write pattern then store strobe programs buffer into page, data ignored.
// - Interrupt stays asserted while enabled and enable bit is clear.
// - Erase or write blocks region reads and sets region busy bit.
// - Busy bit holds after completion until re-enable is issued.
// - Lock pattern then store strobe programs lock bits from data bits 5:0.
// - Each zero data bit among 5:0 programs its lock bit.
// - Lock programming never halts the core.
// - Eeprom write blocks all programming and fuse or lock reads.
// - Address 0001 load strobe within three cycles returns lock byte.
// - Read mode self-clears after read, after three or four idle cycles; here it clears only after four.
// - Addresses 0000, 0003, 0002 return fuse low, high, extended bytes.
// - Programmed bits read zero, unprogrammed bits read one.
// - Erase, write and lock programming last 3.2 to 3.4 ms.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fspu_core
  import fspu_pkg::*;
#(
  parameter int PROG_CYCLES = FSPU_PROG_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        store_strobe,
  input  wire logic        load_strobe,
  input  wire logic [15:0] ptr_addr,
  input  wire logic [15:0] data_pair,
  input  wire logic        eeprom_write_busy,
  input  wire logic [7:0]  fuse_low_byte,
  input  wire logic [7:0]  fuse_high_byte,
  input  wire logic [7:0]  extended_fuse_byte,
  input  wire logic [4:0]  flash_buf_word,
  output logic [15:0]      flash_buf_data,
  output logic             flash_erase_start,
  output logic             flash_write_start,
  output logic [6:0]       flash_page,
  output logic             region_read_block,
  output logic             cpu_halt,
  output logic             load_override,
  output logic [7:0]       load_data,
  output logic             prog_irq
);
  fspu_pbuf_if pbuf ();

  fspu_page_buffer u_buf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pbuf    (pbuf.store)
  );

  // halting region test on a page index
  function automatic logic halts(input logic [6:0] page);
    return page >= FSPU_HALT_PAGE0;
  endfunction

  fspu_state_t state_reg, state_next;
  logic        aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
  logic [7:0]  aw_addr_reg;
  logic [7:0]  w_data_reg;
  logic        w_strb_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [4:0]  cmd_reg;
  logic        ie_reg, region_busy_reg, halt_reg;
  logic [2:0]  elapsed_reg;
  logic [19:0] prog_cnt_reg;
  logic [5:0]  lock_reg, lock_data_reg;
  logic [4:0]  op_reg;
  logic [6:0]  page_reg;
  logic        erase_reg, write_reg, ld_valid_reg, ee_busy_d_reg;
  logic [7:0]  ld_data_reg;

  // bus decode
  wire        wr_fire    = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire        wr_ctrl    = aw_addr_reg == FSPU_CTRL_OFFS;
  wire        wr_mapped  = wr_ctrl || aw_addr_reg == FSPU_LOCK_OFFS;
  wire        ar_fire    = s_axi_arvalid && !rvalid_reg;
  wire        rd_ctrl    = s_axi_araddr == FSPU_CTRL_OFFS;
  wire        rd_lock    = s_axi_araddr == FSPU_LOCK_OFFS;
  wire [7:0]  ctrl_view  = {ie_reg, region_busy_reg, 1'b0, cmd_reg};
  wire [7:0]  lock_byte  = {2'b11, lock_reg};
  // control writes are refused while an eeprom write runs or work is pending
  wire        ctrl_take  = wr_fire && wr_ctrl && w_strb_reg && state_reg == FSPU_IDLE
                           && !eeprom_write_busy;
  wire        arm        = ctrl_take && w_data_reg[0];
  wire        armed      = state_reg == FSPU_ARMED;
  wire        store_take = armed && store_strobe && !eeprom_write_busy;
  wire        load_take  = armed && load_strobe && cmd_reg == FSPU_CMD_LOCK
                           && elapsed_reg <= FSPU_LOAD_WINDOW && !eeprom_write_busy;
  wire        window_end = armed && elapsed_reg == FSPU_STORE_WINDOW && !store_take && !load_take;
  wire        long_op    = store_take && (cmd_reg == FSPU_CMD_ERASE || cmd_reg == FSPU_CMD_WRITE
                                          || cmd_reg == FSPU_CMD_LOCK);
  wire        page_op    = store_take && (cmd_reg == FSPU_CMD_ERASE || cmd_reg == FSPU_CMD_WRITE);
  wire        op_done    = state_reg == FSPU_BUSY && prog_cnt_reg == 20'h00001;
  wire        reenable   = store_take && cmd_reg == FSPU_CMD_REEN;
  wire        ee_start   = eeprom_write_busy && !ee_busy_d_reg;
  wire [6:0]  ptr_page   = ptr_addr[FSPU_PAGE_LSB +: FSPU_PAGE_W];
  wire [19:0] prog_load  = 20'(PROG_CYCLES);

  // timed read source select
  logic [7:0] ld_sel;
  always_comb begin
    unique case (ptr_addr)
      FSPU_ADDR_LOCK:    ld_sel = lock_byte;
      FSPU_ADDR_FUSE_LO: ld_sel = fuse_low_byte;
      FSPU_ADDR_FUSE_HI: ld_sel = fuse_high_byte;
      FSPU_ADDR_FUSE_EX: ld_sel = extended_fuse_byte;
      default:           ld_sel = 8'hff;
    endcase
  end

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FSPU_IDLE:  if (arm) state_next = FSPU_ARMED;
      FSPU_ARMED: begin
        if (long_op) begin
          state_next = FSPU_BUSY;
        end else if (store_take || load_take || window_end) begin
          state_next = FSPU_IDLE;
        end
      end
      FSPU_BUSY:  if (op_done) state_next = FSPU_IDLE;
      default:    state_next = FSPU_IDLE;
    endcase
  end

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_mapped ? 2'b00 : 2'b11;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read channel: one cycle to answer, unmapped gives decode error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= 2'b00;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h00_0000, rd_ctrl ? ctrl_view : (rd_lock ? lock_byte : 8'h00)};
      rresp_reg  <= (rd_ctrl || rd_lock) ? 2'b00 : 2'b11;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // command bits and window timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= FSPU_IDLE;
      cmd_reg     <= FSPU_CMD_RESET;
      ie_reg      <= 1'b0;
      elapsed_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      if (ctrl_take) begin
        ie_reg      <= w_data_reg[FSPU_IE_POS];
        cmd_reg     <= w_data_reg[0] ? w_data_reg[4:0] : FSPU_CMD_RESET;
        elapsed_reg <= 3'h1;
      end else if (armed && !long_op && (store_take || load_take || window_end)) begin
        cmd_reg <= FSPU_CMD_RESET;
      end else if (op_done) begin
        cmd_reg <= FSPU_CMD_RESET;
      end else if (armed) begin
        elapsed_reg <= elapsed_reg + 3'h1;
      end
    end
  end

  // operation launch and timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_cnt_reg  <= 20'h00000;
      op_reg        <= FSPU_CMD_RESET;
      page_reg      <= 7'h00;
      lock_data_reg <= FSPU_LOCK_RESET;
      erase_reg     <= 1'b0;
      write_reg     <= 1'b0;
      halt_reg      <= 1'b0;
    end else begin
      erase_reg <= store_take && cmd_reg == FSPU_CMD_ERASE;
      write_reg <= store_take && cmd_reg == FSPU_CMD_WRITE;
      if (long_op) begin
        prog_cnt_reg  <= prog_load;
        op_reg        <= cmd_reg;
        page_reg      <= ptr_page;
        lock_data_reg <= data_pair[5:0];
        halt_reg      <= page_op && halts(ptr_page);
      end else if (state_reg == FSPU_BUSY) begin
        prog_cnt_reg <= prog_cnt_reg - 20'h00001;
        if (op_done) begin
          halt_reg <= 1'b0;
        end
      end
    end
  end

  // region busy and lock bits; a completing op never fights re-enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      region_busy_reg <= 1'b0;
      lock_reg        <= FSPU_LOCK_RESET;
      ee_busy_d_reg   <= 1'b0;
    end else begin
      ee_busy_d_reg <= eeprom_write_busy;
      if (page_op) begin
        region_busy_reg <= 1'b1;
      end else if (reenable) begin
        region_busy_reg <= 1'b0;
      end
      if (op_done && op_reg == FSPU_CMD_LOCK) begin
        lock_reg <= lock_reg & lock_data_reg;
      end
    end
  end

  // timed read of fuse and lock bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ld_valid_reg <= 1'b0;
      ld_data_reg  <= 8'hff;
    end else begin
      ld_valid_reg <= load_take;
      if (load_take) begin
        ld_data_reg <= ld_sel;
      end
    end
  end

  // page buffer steering
  assign pbuf.load    = store_take && cmd_reg == FSPU_CMD_LOAD;
  assign pbuf.word    = ptr_addr[FSPU_WORD_LSB +: FSPU_WORD_W];
  assign pbuf.data    = data_pair;
  // eeprom start and re-enable discard the buffer; clear beats a same-cycle load
  assign pbuf.clear   = (op_done && op_reg == FSPU_CMD_WRITE) || reenable || ee_start;
  assign pbuf.rd_word = flash_buf_word;

  assign s_axi_awready     = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready      = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid      = bvalid_reg;
  assign s_axi_bresp       = bresp_reg;
  assign s_axi_arready     = !rvalid_reg;
  assign s_axi_rvalid      = rvalid_reg;
  assign s_axi_rdata       = rdata_reg;
  assign s_axi_rresp       = rresp_reg;
  assign flash_buf_data    = pbuf.rd_data;
  assign flash_erase_start = erase_reg;
  assign flash_write_start = write_reg;
  assign flash_page        = page_reg;
  assign region_read_block = region_busy_reg;
  assign cpu_halt          = halt_reg;
  assign load_override     = ld_valid_reg;
  assign load_data         = ld_data_reg;
  // level request, not a pulse, so polling and interrupt agree
  assign prog_irq          = ie_reg && !cmd_reg[0];

  // helper: cycles spent busy
  logic [19:0] busy_len_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || state_reg != FSPU_BUSY) begin
      busy_len_reg <= 20'h00000;
    end else begin
      busy_len_reg <= busy_len_reg + 20'h00001;
    end
  end

  sequence s_armed_quiet;
    (armed && !store_strobe && !load_strobe) [*4];
  endsequence

  AST_IRQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
    ie_reg && state_reg == FSPU_IDLE |-> prog_irq)
    else $error("interrupt not held while enable bit clear");
  AST_TIMEOUT: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(armed) ##0 s_armed_quiet |=> state_reg == FSPU_IDLE && cmd_reg == 5'h00 && !erase_reg)
    else $error("window expired without clearing command");
  AST_DURATION: assert property (@(posedge aclk) disable iff (!aresetn)
    op_done |-> busy_len_reg == prog_load - 20'h00001)
    else $error("programming time wrong");
  AST_ENABLE_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == FSPU_BUSY |-> cmd_reg[0]) and (op_done |=> !cmd_reg[0]))
    else $error("enable bit not held through operation");
  AST_BUSY_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
    region_busy_reg && !reenable |=> region_busy_reg)
    else $error("region busy dropped without re-enable");
  AST_LOCK_NOHALT: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == FSPU_BUSY && op_reg == FSPU_CMD_LOCK |-> !cpu_halt)
    else $error("core halted during lock programming");
  AST_EE_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
    eeprom_write_busy && state_reg == FSPU_IDLE |=> state_reg == FSPU_IDLE)
    else $error("operation armed during eeprom write");
  AST_LOCK_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    load_take && ptr_addr == FSPU_ADDR_LOCK |=> load_override && load_data == {2'b11, $past(lock_reg)})
    else $error("lock byte not returned");
  AST_READ_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
    load_take |=> !cmd_reg[0] && state_reg == FSPU_IDLE)
    else $error("read mode not cleared after read");
  AST_PAGE_BUSY: assert property (@(posedge aclk) disable iff (!aresetn)
    page_op |=> region_read_block [*2])
    else $error("region not blocked during page operation");
endmodule
`default_nettype wire

//--- verilog/fspu_page_buffer.sv
// fspu_page_buffer: word-addressed temporary page buffer
// assumes load and clear pulses from the sequencer on the same clock
`timescale 1ns/1ps
`default_nettype none
module fspu_page_buffer
  import fspu_pkg::*;
(
  input  wire logic  aclk,
  input  wire logic  aresetn,
  fspu_pbuf_if.store pbuf
);
  logic [15:0] mem_reg [FSPU_WORDS];
  logic [15:0] rd_reg;

  // clear wins over load; reset empties too
  always_ff @(posedge aclk) begin
    if (!aresetn || pbuf.clear) begin
      for (int i = 0; i < FSPU_WORDS; i++) begin
        mem_reg[i] <= FSPU_WORD_ERASED;
      end
    end else if (pbuf.load) begin
      mem_reg[pbuf.word] <= pbuf.data; // any word order accepted
    end
  end

  // registered read port toward the flash array
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_reg <= FSPU_WORD_ERASED;
    end else begin
      rd_reg <= mem_reg[pbuf.rd_word];
    end
  end

  assign pbuf.rd_data = rd_reg;
endmodule
`default_nettype wire

//--- verilog/fspu_pbuf_if.sv
// fspu_pbuf_if: port between the sequencer and the temporary page buffer
// assumes both ends on the core clock
`timescale 1ns/1ps
`default_nettype none
interface fspu_pbuf_if;
  logic        load;
  logic        clear;
  logic [4:0]  word;
  logic [15:0] data;
  logic [4:0]  rd_word;
  logic [15:0] rd_data;
  modport ctrl  (output load, clear, word, data, rd_word, input rd_data);
  modport store (input load, clear, word, data, rd_word, output rd_data);
endinterface
`default_nettype wire

//--- verilog/fspu_pkg.sv
// fspu_pkg: constants and types of the flash self-programming unit
// assumes a 250 MHz core clock and a 32-bit AXI4-Lite register bus
package fspu_pkg;
  // timing
  localparam int FSPU_CLK_PERIOD_NS = 4;
  localparam int FSPU_PROG_MIN_NS   = 3200000;
  localparam int FSPU_PROG_MAX_NS   = 3400000;
  localparam int FSPU_PROG_CYCLES   = (FSPU_PROG_MIN_NS + FSPU_CLK_PERIOD_NS - 1) / FSPU_CLK_PERIOD_NS;
  localparam int FSPU_PROG_MAX_CYC  = FSPU_PROG_MAX_NS / FSPU_CLK_PERIOD_NS;
  localparam logic [2:0] FSPU_STORE_WINDOW = 3'h4;
  localparam logic [2:0] FSPU_LOAD_WINDOW  = 3'h3;
  // register byte offsets
  localparam logic [7:0] FSPU_CTRL_OFFS = 8'h00;
  localparam logic [7:0] FSPU_LOCK_OFFS = 8'h04;
  // control/status field positions
  localparam int FSPU_IE_POS   = 7;
  localparam int FSPU_BUSY_POS = 6;
  // command patterns in control bits 4:0, enable bit is bit 0
  localparam logic [4:0] FSPU_CMD_LOAD  = 5'h01;
  localparam logic [4:0] FSPU_CMD_ERASE = 5'h03;
  localparam logic [4:0] FSPU_CMD_WRITE = 5'h05;
  localparam logic [4:0] FSPU_CMD_LOCK  = 5'h09;
  localparam logic [4:0] FSPU_CMD_REEN  = 5'h11;
  // address pointer fields
  localparam int FSPU_WORD_LSB = 1;
  localparam int FSPU_WORD_W   = 5;
  localparam int FSPU_PAGE_LSB = 6;
  localparam int FSPU_PAGE_W   = 7;
  localparam int FSPU_WORDS    = 32;
  localparam logic [6:0] FSPU_HALT_PAGE0 = 7'h70;
  // timed read addresses
  localparam logic [15:0] FSPU_ADDR_FUSE_LO = 16'h0000;
  localparam logic [15:0] FSPU_ADDR_LOCK    = 16'h0001;
  localparam logic [15:0] FSPU_ADDR_FUSE_EX = 16'h0002;
  localparam logic [15:0] FSPU_ADDR_FUSE_HI = 16'h0003;
  // reset values
  localparam logic [4:0]  FSPU_CMD_RESET  = 5'h00;
  localparam logic [5:0]  FSPU_LOCK_RESET = 6'h3f;
  localparam logic [15:0] FSPU_WORD_ERASED = 16'hffff;
  typedef enum logic [1:0] {
    FSPU_IDLE  = 2'b00,
    FSPU_ARMED = 2'b01,
    FSPU_BUSY  = 2'b10
  } fspu_state_t;
endpackage
